// [epv_board_mon.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// board side monitor counting error pin assertions
// ****************************************************************
module epv_board_mon (
  input  wire logic        clk,
  input  wire logic [2:0]  err_pin,
  output logic [2:0][15:0] rise_cnt
);
  logic [2:0] last_r;

  initial begin
    last_r   = 3'h0;
    rise_cnt = '0;
  end

  // the board only sees levels, so it counts low to high steps per pin
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (err_pin[i] && !last_r[i]) rise_cnt[i] <= rise_cnt[i] + 16'h0001;
    end
    last_r <= err_pin;
  end
endmodule : epv_board_mon
`default_nettype wire

// [epv_pin_drv.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one error pin: mode select and assertion edge
// ****************************************************************
module epv_pin_drv (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire epv_pkg::epv_mode_t mode,
  input  wire logic              sev,
  input  wire logic              dat,
  output logic                   pin,
  output logic                   rise
);

  typedef struct packed {
    logic pin;
  } epv_pin_st_t;

  epv_pin_st_t st_r;
  epv_pin_st_t st_nxt;

  // reserved code behaves as disabled so a bad write cannot fire the pin
  always_comb begin
    st_nxt = st_r;
    unique case (mode)
      epv_pkg::EPV_MODE_SEV: st_nxt.pin = sev;
      epv_pkg::EPV_MODE_GPO: st_nxt.pin = dat;
      epv_pkg::EPV_MODE_OFF: st_nxt.pin = 1'b0;
      epv_pkg::EPV_MODE_RSV: st_nxt.pin = 1'b0;
    endcase
  end

  // pin level is not sticky, it restarts deasserted
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.pin <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign pin  = st_r.pin;
  assign rise = ce & ~srst & st_nxt.pin & ~st_r.pin;

endmodule : epv_pin_drv
`default_nettype wire

// [epv_pkg.sv]
// ****************************************************************
// shared constants and types for the error pin and viral block
// ****************************************************************
package epv_pkg;

  localparam int unsigned NPINS = 3;

  // register byte offsets
  localparam logic [7:0] OFS_VIRAL_CFG = 8'ha0;
  localparam logic [7:0] OFS_PIN_CTL   = 8'ha4;
  localparam logic [7:0] OFS_PIN_STS   = 8'ha8;
  localparam logic [7:0] OFS_PIN_DAT   = 8'hac;
  localparam logic [7:0] OFS_IRQ_STS   = 8'hd0;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'hd4;

  // field positions
  localparam int unsigned VIRAL_EN_BIT = 2;
  localparam int unsigned CTL_W        = 2;
  localparam int unsigned IRQ_VIRAL    = 3;

  // values after reset
  localparam logic [5:0]  CTL_RST   = 6'h00;
  localparam logic [2:0]  PIN_RST   = 3'h0;
  localparam logic [3:0]  IRQ_RST   = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // pin behaviour selected by a control field
  typedef enum logic [1:0] {
    EPV_MODE_OFF = 2'h0,
    EPV_MODE_GPO = 2'h1,
    EPV_MODE_SEV = 2'h2,
    EPV_MODE_RSV = 2'h3
  } epv_mode_t;

  // bus request carried as one bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } epv_bus_req_t;

  // all state of the top module
  typedef struct packed {
    logic        viral_en;
    logic [5:0]  ctl;
    logic [2:0]  pst;
    logic [2:0]  dat;
    logic [3:0]  ist;
    logic [3:0]  imask;
    logic [31:0] rdata;
    logic        irq;
  } epv_regs_t;

  // control field of one pin
  function automatic epv_mode_t ctl_field(input logic [5:0] ctl, input int unsigned idx);
    ctl_field = epv_mode_t'(ctl[idx*CTL_W +: CTL_W]);
  endfunction : ctl_field

endpackage : epv_pkg

// [epv_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - fatal severity enters viral only when enabled
// - two-bit control field per pin, reset zero
// - mode 10 follows matching severity bit
// - mode 01 follows the pin data bit
// - mode 00 never asserts; 11 reserved
// - status bit set on pin assertion edge
// - writing one clears status, zero keeps
// - data one asserts, zero deasserts, reset zero
// - data bit ignored unless mode is 01
module epv_top (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       pg_rst,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [2:0] sev_status,
  output logic      [31:0] rdata,
  output logic      [2:0] err_pin,
  output logic            viral,
  output logic            irq
);

  // ****************************************************************
  // state and bus bundle
  // ****************************************************************
  epv_pkg::epv_regs_t    st_r;
  epv_pkg::epv_regs_t    st_nxt;
  epv_pkg::epv_bus_req_t req;
  logic [2:0]            pin_lvl;
  logic [2:0]            pin_rise;
  logic                  vir_lvl;
  logic                  vir_entry;
  logic                  any_rst;

  assign any_rst = srst | pg_rst;

  // bundle the bus for the decode below
  assign req.addr  = addr;
  assign req.wdata = wdata;
  assign req.wr    = wr;
  assign req.rd    = rd;

  // ****************************************************************
  // pin drivers and viral tracker
  // ****************************************************************
  // per-pin mode select, each fed its own severity and data bit
  for (genvar gi = 0; gi < epv_pkg::NPINS; gi++) begin : g_pin
    epv_pin_drv u_pin (
      .clk  (clk),
      .srst (any_rst),
      .ce   (ce),
      .mode (epv_pkg::ctl_field(st_r.ctl, gi)),
      .sev  (sev_status[gi]),
      .dat  (st_r.dat[gi]),
      .pin  (pin_lvl[gi]),
      .rise (pin_rise[gi])
    );
  end

  epv_viral u_viral (
    .clk      (clk),
    .srst     (any_rst),
    .ce       (ce),
    .fatal_en (st_r.viral_en),
    .sev2     (sev_status[2]),
    .viral    (vir_lvl),
    .entry    (vir_entry)
  );

  // ****************************************************************
  // register file next state
  // ****************************************************************
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = epv_pkg::RDATA_RST;
    st_nxt.pst = st_r.pst;
    if (req.wr && req.addr == epv_pkg::OFS_PIN_STS) begin
      st_nxt.pst = st_r.pst & ~req.wdata[2:0];
    end
    // set wins over a clear landing in the same cycle
    st_nxt.pst = st_nxt.pst | pin_rise;
    if (req.wr) begin
      unique case (req.addr)
        epv_pkg::OFS_VIRAL_CFG: st_nxt.viral_en = req.wdata[epv_pkg::VIRAL_EN_BIT];
        epv_pkg::OFS_PIN_CTL:   st_nxt.ctl = req.wdata[5:0];
        epv_pkg::OFS_PIN_DAT:   st_nxt.dat = req.wdata[2:0];
        epv_pkg::OFS_IRQ_MASK:  st_nxt.imask = req.wdata[3:0];
        default: ;
      endcase
    end
    // interrupt status: read clears, then fresh events set
    if (req.rd) begin
      unique case (req.addr)
        epv_pkg::OFS_VIRAL_CFG:
          st_nxt.rdata = {29'h0, st_r.viral_en, 2'h0};
        epv_pkg::OFS_PIN_CTL:   st_nxt.rdata = {26'h0, st_r.ctl};
        epv_pkg::OFS_PIN_STS:   st_nxt.rdata = {29'h0, st_r.pst};
        epv_pkg::OFS_PIN_DAT:   st_nxt.rdata = {29'h0, st_r.dat};
        epv_pkg::OFS_IRQ_STS: begin
          st_nxt.rdata = {28'h0, st_r.ist};
          st_nxt.ist   = epv_pkg::IRQ_RST;
        end
        epv_pkg::OFS_IRQ_MASK:  st_nxt.rdata = {28'h0, st_r.imask};
        default:                st_nxt.rdata = epv_pkg::RDATA_RST;
      endcase
    end
    st_nxt.ist[2:0]                 = st_nxt.ist[2:0] | pin_rise;
    st_nxt.ist[epv_pkg::IRQ_VIRAL]  = st_nxt.ist[epv_pkg::IRQ_VIRAL] | vir_entry;
    st_nxt.irq                      = |(st_nxt.ist & st_nxt.imask);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // warm reset keeps the sticky group, power-good clears everything
  always_ff @(posedge clk) begin
    if (pg_rst) begin
      st_r <= '0;
    end else if (srst) begin
      st_r.dat   <= epv_pkg::PIN_RST;
      st_r.ist   <= epv_pkg::IRQ_RST;
      st_r.imask <= epv_pkg::IRQ_RST;
      st_r.rdata <= epv_pkg::RDATA_RST;
      st_r.irq   <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rdata   = st_r.rdata;
  assign err_pin = pin_lvl;
  assign viral   = vir_lvl;
  assign irq     = st_r.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (any_rst);

  property p_viral_enter;
    ce && st_r.viral_en && sev_status[2] |=> viral;
  endproperty
  a_viral_enter: assert property (p_viral_enter)
    else $error("viral not entered on enabled fatal");

  property p_viral_gated;
    $rose(viral) |-> $past(st_r.viral_en) && $past(sev_status[2]);
  endproperty
  a_viral_gated: assert property (p_viral_gated)
    else $error("viral entered without enable");

  property p_viral_off;
    !st_r.viral_en && !viral |=> !viral;
  endproperty
  a_viral_off: assert property (p_viral_off)
    else $error("viral entered while disabled");

  property p_viral_hold;
    viral |=> viral;
  endproperty
  a_viral_hold: assert property (p_viral_hold)
    else $error("viral state dropped without reset");

  property p_ven_read;
    ce && rd && addr == epv_pkg::OFS_VIRAL_CFG
      |=> rdata == {29'h0, $past(st_r.viral_en), 2'h0};
  endproperty
  a_ven_read: assert property (p_ven_read)
    else $error("viral enable read mismatch");

  property p_ctl_write;
    ce && wr && addr == epv_pkg::OFS_PIN_CTL |=> st_r.ctl == $past(wdata[5:0]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control field write lost");

  property p_ctl_read;
    ce && rd && addr == epv_pkg::OFS_PIN_CTL |=> rdata == {26'h0, $past(st_r.ctl)};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control register read mismatch");

  property p_pg_clear;
    @(posedge clk) disable iff (1'b0)
      pg_rst |=> st_r.ctl == epv_pkg::CTL_RST && st_r.pst == epv_pkg::PIN_RST
        && !st_r.viral_en;
  endproperty
  a_pg_clear: assert property (p_pg_clear)
    else $error("power-good reset left sticky field set");

  for (genvar ai = 0; ai < epv_pkg::NPINS; ai++) begin : g_chk
    property p_sev_mode;
      ce && epv_pkg::ctl_field(st_r.ctl, ai) == epv_pkg::EPV_MODE_SEV
        |=> err_pin[ai] == $past(sev_status[ai]);
    endproperty
    a_sev_mode: assert property (p_sev_mode)
      else $error("pin does not follow severity");

    property p_gpo_mode;
      ce && epv_pkg::ctl_field(st_r.ctl, ai) == epv_pkg::EPV_MODE_GPO
        |=> err_pin[ai] == $past(st_r.dat[ai]);
    endproperty
    a_gpo_mode: assert property (p_gpo_mode)
      else $error("pin does not follow data bit");

    property p_off_mode;
      ce && (epv_pkg::ctl_field(st_r.ctl, ai) == epv_pkg::EPV_MODE_OFF ||
             epv_pkg::ctl_field(st_r.ctl, ai) == epv_pkg::EPV_MODE_RSV)
        |=> !err_pin[ai];
    endproperty
    a_off_mode: assert property (p_off_mode)
      else $error("disabled pin asserted");

    property p_dat_ignored;
      ce && epv_pkg::ctl_field(st_r.ctl, ai) != epv_pkg::EPV_MODE_GPO && !sev_status[ai]
        |=> !err_pin[ai];
    endproperty
    a_dat_ignored: assert property (p_dat_ignored)
      else $error("data bit leaked to pin");

    property p_sts_set;
      $rose(err_pin[ai]) |-> st_r.pst[ai];
    endproperty
    a_sts_set: assert property (p_sts_set)
      else $error("status not set on assertion");

    property p_sts_quiet;
      ce && !pin_rise[ai] && !st_r.pst[ai] |=> !st_r.pst[ai];
    endproperty
    a_sts_quiet: assert property (p_sts_quiet)
      else $error("status set without assertion edge");

    property p_sts_clr;
      ce && wr && addr == epv_pkg::OFS_PIN_STS && wdata[ai] && !pin_rise[ai]
        |=> !st_r.pst[ai];
    endproperty
    a_sts_clr: assert property (p_sts_clr)
      else $error("write one did not clear status");

    property p_sts_keep;
      ce && wr && addr == epv_pkg::OFS_PIN_STS && !wdata[ai] && st_r.pst[ai]
        |=> st_r.pst[ai];
    endproperty
    a_sts_keep: assert property (p_sts_keep)
      else $error("write zero cleared status");
  end

  property p_sts_read;
    ce && rd && addr == epv_pkg::OFS_PIN_STS |=> rdata == {29'h0, $past(st_r.pst)};
  endproperty
  a_sts_read: assert property (p_sts_read)
    else $error("status register read mismatch");

  property p_dat_read;
    ce && rd && addr == epv_pkg::OFS_PIN_DAT |=> rdata == {29'h0, $past(st_r.dat)};
  endproperty
  a_dat_read: assert property (p_dat_read)
    else $error("data register read mismatch");

  property p_warm_clr;
    @(posedge clk) disable iff (pg_rst)
      srst |=> st_r.dat == epv_pkg::PIN_RST && !viral && err_pin == 3'h0;
  endproperty
  a_warm_clr: assert property (p_warm_clr)
    else $error("warm reset left data or pins set");

  property p_warm_keep;
    @(posedge clk) disable iff (pg_rst)
      srst |=> st_r.ctl == $past(st_r.ctl) && st_r.viral_en == $past(st_r.viral_en);
  endproperty
  a_warm_keep: assert property (p_warm_keep)
    else $error("sticky field lost on warm reset");

  property p_warm_sts;
    @(posedge clk) disable iff (pg_rst)
      srst |=> st_r.pst == $past(st_r.pst);
  endproperty
  a_warm_sts: assert property (p_warm_sts)
    else $error("pin status lost on warm reset");

  // clock enable low freezes the outputs
  property p_ce_freeze;
    !ce |=> $stable(err_pin) && $stable(viral) && $stable(rdata) && $stable(irq);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while clock enable low");

  // read data stands for one cycle only
  property p_rdata_idle;
    ce && !rd |=> rdata == epv_pkg::RDATA_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after read");

  // pending unmasked event holds irq
  property p_irq_level;
    ce && !wr && !rd && |(st_r.ist & st_r.imask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level mismatch");

  // irq status cleared by its read
  property p_ist_clear;
    ce && rd && addr == epv_pkg::OFS_IRQ_STS && !(|pin_rise) && !vir_entry
      |=> st_r.ist == epv_pkg::IRQ_RST;
  endproperty
  a_ist_clear: assert property (p_ist_clear)
    else $error("interrupt status not cleared by read");

endmodule : epv_top
`default_nettype wire

// [epv_viral.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// viral state tracker
// ****************************************************************
module epv_viral (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic fatal_en,
  input  wire logic sev2,
  output logic      viral,
  output logic      entry
);

  typedef struct packed {
    logic viral;
  } epv_vir_st_t;

  epv_vir_st_t st_r;
  epv_vir_st_t st_nxt;

  // once viral, only a reset brings the hub back
  always_comb begin
    st_nxt = st_r;
    if (fatal_en && sev2) begin
      st_nxt.viral = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.viral <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign viral = st_r.viral;
  assign entry = ce & ~srst & st_nxt.viral & ~st_r.viral;

endmodule : epv_viral
`default_nettype wire

// [error_pin_viral_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the error pin and viral block
// ****************************************************************
module error_pin_viral_control_test;
  logic clk, srst, pg_rst, ce, wr, rd, viral, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, lfsr;
  logic [2:0] sev_status, err_pin;
  logic [2:0][15:0] rise_cnt;
  int mismatches, n_tests;
  int m_ven, m_ctl, m_pst, m_dat, m_ist, m_imask, m_pin, m_viral, m_rdata;
  int m_cnt[3];
  logic [7:0] ra[7] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hd0, 8'hd4, 8'h10};

  epv_top DUT (.clk(clk), .srst(srst), .pg_rst(pg_rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .sev_status(sev_status), .rdata(rdata),
    .err_pin(err_pin), .viral(viral), .irq(irq));
  epv_board_mon mon (.clk(clk), .err_pin(err_pin), .rise_cnt(rise_cnt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // one bus cycle; strobes are set each call so back to back is legal
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= r;
  endtask : op

  // pin level chosen by each two-bit field; code 11 acts as off
  function automatic int mpins(input int ctl, input int sev, input int dat);
    int md;
    mpins = 0;
    for (int i = 0; i < 3; i++) begin
      md = (ctl >> (2 * i)) & 3;
      if (md == 2) mpins |= sev & (1 << i);
      if (md == 1) mpins |= dat & (1 << i);
    end
  endfunction : mpins

  // ****************************************************************
  // reference model, updated with the same edge as the design
  // ****************************************************************
  always @(posedge clk) begin : model
    int np, rv, ent, rise;
    if (pg_rst) begin
      {m_ven, m_ctl, m_pst, m_dat, m_ist, m_imask, m_pin, m_viral, m_rdata} = '0;
    end else if (srst) begin
      {m_dat, m_ist, m_imask, m_pin, m_viral, m_rdata} = '0;
    end else if (ce) begin
      np   = mpins(m_ctl, sev_status, m_dat);
      rise = np & ~m_pin;
      ent  = (m_ven && sev_status[2] && !m_viral) ? 8 : 0;
      rv   = 0;
      if (rd) begin
        case (addr)
          8'ha0: rv = m_ven << 2;
          8'ha4: rv = m_ctl;
          8'ha8: rv = m_pst;
          8'hac: rv = m_dat;
          8'hd0: rv = m_ist;
          8'hd4: rv = m_imask;
          default: rv = 0;
        endcase
      end
      m_rdata = rv;
      for (int i = 0; i < 3; i++) m_cnt[i] += (rise >> i) & 1;
      if (wr && addr == 8'ha8) m_pst &= ~(wdata & 7);
      m_pst |= rise;
      if (rd && addr == 8'hd0) m_ist = 0;
      m_ist |= rise | ent;
      if (m_ven && sev_status[2]) m_viral = 1;
      if (wr && addr == 8'ha0) m_ven = (wdata >> 2) & 1;
      if (wr && addr == 8'ha4) m_ctl = wdata & 63;
      if (wr && addr == 8'hac) m_dat = wdata & 7;
      if (wr && addr == 8'hd4) m_imask = wdata & 15;
      m_pin = np;
    end
  end

  always @(negedge clk) begin
    if (n_tests >= 0 && $time > 30) begin
      check(32'(err_pin), m_pin);
      check(32'(viral), m_viral);
      check(rdata, m_rdata);
    end
  end

  // settled interrupt level against masked sticky status
  task automatic chk_irq;
    repeat (4) op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
    @(negedge clk);
    check(32'(irq), 32'((m_ist & m_imask) != 0));
    @(posedge clk);
  endtask : chk_irq

  task automatic read_all;
    foreach (ra[i]) op(ra[i], 32'h0000_0000, 1'b0, 1'b1);
    op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
  endtask : read_all

  initial begin
    #(8 * 20000);
    mismatches++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {srst, pg_rst, ce, wr, rd} = 5'b11100;
    {addr, wdata, sev_status} = '0;
    lfsr = 32'd80055;
    {mismatches, n_tests} = '0;
    m_cnt = '{0, 0, 0};
    repeat (3) @(posedge clk);
    srst   <= 1'b0;
    pg_rst <= 1'b0;
    read_all();
    op(8'ha0, 32'h0000_0000, 1'b1, 1'b0);
    op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
    sev_status <= 3'h4;
    op(8'hd4, 32'h0000_000f, 1'b1, 1'b0);
    op(8'ha0, 32'h0000_0004, 1'b1, 1'b0);
    chk_irq();
    op(8'hd0, 32'h0000_0000, 1'b0, 1'b1);
    chk_irq();
    // random traffic over modes 00, 01 and 10, data, clear and stall
    for (int k = 0; k < 400; k++) begin
      lfsr = step(lfsr);
      case (lfsr[2:0])
        3'd0: op(8'ha4, {26'h0, 2'(lfsr[9:8] % 3), 2'(lfsr[7:6] % 3), 2'(lfsr[5:4] % 3)},
                 1'b1, 1'b0);
        3'd1: op(8'hac, 32'(lfsr[6:4]), 1'b1, 1'b0);
        3'd2: op(8'ha8, 32'(lfsr[6:4]), 1'b1, 1'b0);
        3'd3: op(ra[lfsr[6:4] % 7], 32'h0000_0000, 1'b0, 1'b1);
        3'd4: op(8'hd4, 32'(lfsr[7:4]), 1'b1, 1'b0);
        3'd5: begin
          op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
          ce <= 1'b0;
          sev_status <= lfsr[6:4];
          op(8'ha4, 32'h0000_0015, 1'b1, 1'b0);
          op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
          ce <= 1'b1;
        end
        3'd6: op(8'ha0, 32'(lfsr[6:4]), 1'b1, 1'b0);
        default: chk_irq();
      endcase
      if (lfsr[12]) sev_status <= lfsr[15:13];
      if (k == 200) begin
        op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
        srst <= 1'b1;
        op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
        srst <= 1'b0;
        read_all();
      end
    end
    chk_irq();
    read_all();
    @(negedge clk);
    for (int i = 0; i < 3; i++) check(32'(rise_cnt[i]), m_cnt[i]);
    op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
    pg_rst <= 1'b1;
    op(8'h00, 32'h0000_0000, 1'b0, 1'b0);
    pg_rst <= 1'b0;
    read_all();
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule : error_pin_viral_control_test
`default_nettype wire
